// [logic/irc_pkg.sv]
// Purpose: shared constants for the interrupt request controller
// Assumes: 32-bit APB, 10 MHz system clock
// Notes:   register index times four gives the APB byte address
package irc_pkg;
	// bus geometry
	localparam int unsigned DATA_W    = 32;           // apb data width
	localparam int unsigned ADDR_W    = 16;           // apb address width
	localparam int unsigned IDX_W     = ADDR_W - 2;   // word index width

	// source counts
	localparam int unsigned SRC_NUM   = 24;           // all request sources
	localparam int unsigned LVL_NUM   = 16;           // level-type sources
	localparam int unsigned EDGE_NUM  = 8;            // edge-type sources
	localparam int unsigned SRC_ID_W  = 5;            // width of a source number
	localparam int unsigned PIN_NUM   = 32;           // default pin count

	// register indices
	localparam logic [IDX_W-1:0] IDX_ENABLE_0  = 14'h0640;
	localparam logic [IDX_W-1:0] IDX_ENABLE_1  = 14'h0641;
	localparam logic [IDX_W-1:0] IDX_ENABLE_2  = 14'h0642;
	localparam logic [IDX_W-1:0] IDX_GLOBAL    = 14'h0643;
	localparam logic [IDX_W-1:0] IDX_PRIORITY_SELECT_0    = 14'h0644;
	localparam logic [IDX_W-1:0] IDX_PRIORITY_SELECT_1    = 14'h0645;
	localparam logic [IDX_W-1:0] IDX_PRIORITY_SELECT_2    = 14'h0646;
	localparam logic [IDX_W-1:0] IDX_FLAGS_0   = 14'h0648;
	localparam logic [IDX_W-1:0] IDX_FLAGS_1   = 14'h0649;
	localparam logic [IDX_W-1:0] IDX_FLAGS_2   = 14'h064A;
	localparam logic [IDX_W-1:0] IDX_PIN_POL   = 14'h0650;
	localparam logic [IDX_W-1:0] IDX_PIN_IRQEN = 14'h0651;
	localparam logic [IDX_W-1:0] IDX_PIN_MASK0 = 14'h0652;
	localparam logic [IDX_W-1:0] IDX_PIN_MASK1 = 14'h0653;

	// field positions
	localparam int unsigned GLOBAL_EN_BIT  = 0;       // global enable in control byte
	localparam int unsigned EDGE_IDLE_BIT  = 0;       // bus idle source
	localparam int unsigned EDGE_BRST_BIT  = 1;       // usb bus reset source
	localparam int unsigned EDGE_PIN_BIT   = 2;       // pin request source
	localparam int unsigned EDGE_LFW_BIT   = 3;       // low-frequency wakeup
	localparam int unsigned EDGE_STMR_BIT  = 4;       // system timer
	localparam int unsigned EDGE_P2C0_BIT  = 5;       // first pin-to-core request
	localparam int unsigned EDGE_P2C1_BIT  = 6;       // second pin-to-core request

	// reset values
	localparam logic [SRC_NUM-1:0]  ENABLE_RST = 24'h000000;
	localparam logic [SRC_NUM-1:0]  PRIO_RST   = 24'h000000;
	localparam logic [EDGE_NUM-1:0] FLAG_RST   = 8'h00;
	localparam logic                GLOBAL_RST = 1'b0;

	// timing
	localparam int unsigned CLK_PERIOD_NS = 100;      // 10 MHz system clock
	localparam int unsigned IDLE_TIME_NS  = 250000;   // 250 us bus idle
	localparam int unsigned IDLE_CYCLES   =
		(IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned IDLE_CNT_W    = 12;       // holds IDLE_CYCLES
	localparam logic [IDLE_CNT_W-1:0] IDLE_LAST =
		IDLE_CNT_W'(IDLE_CYCLES - 1);
endpackage

// [logic/irc_top.sv]
// Purpose: interrupt request controller with apb register file
// Assumes: level sources and usb signals share the system clock;
//          pins, system timer and wakeup requests arrive asynchronously
// Notes:   answers every apb access with one wait state
//
// Functional notes
// - twenty-four sources: sixteen level, eight edge
// - per-source enable bytes; cleared bit masks source
// - first enable byte maps host, serial, fifo, timers
// - second enable byte maps pke, pwm, radio, usb
// - edge byte maps pins, timers, pin, usb
// - bus idle fires after 250 us idle
// - control bit zero gates every request
// - three priority bytes select high or low
// - priority decides which source goes first
// - three flag bytes show raised requests
// - flag word mirrors enable bit positions
// - edge flag cleared by writing one
// - level flag follows its source module
// - pin request ORs polarity-corrected enabled pins
// - pin-to-core requests use the first and second selection masks
`timescale 1ns/1ps
module irc_top
	import irc_pkg::*;
#(
	parameter int unsigned PIN_COUNT = irc_pkg::PIN_NUM
)
(
	input  wire logic                             clock,
	input  wire logic                             reset,
	input  wire logic [irc_pkg::ADDR_W-1:0]       paddr,
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [irc_pkg::DATA_W-1:0]       pwdata,
	output logic      [irc_pkg::DATA_W-1:0]       prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	input  wire logic [irc_pkg::LVL_NUM-1:0]      level_requests,
	input  wire logic                             usb_bus_reset,
	input  wire logic                             usb_link_idle,
	input  wire logic                             system_timer_request,
	input  wire logic                             low_freq_wakeup_request,
	input  wire logic [PIN_COUNT-1:0]             pin_in,
	output logic                                  core_irq,
	output logic      [irc_pkg::SRC_ID_W-1:0]     core_irq_source,
	output logic                                  core_irq_high
);
	import irc_pkg::*;

	localparam int unsigned AW = PIN_COUNT + 2;   // synchronised inputs

	// software registers
	logic [SRC_NUM-1:0]   enable_r;           // per-source enables
	logic                 global_r;           // global enable
	logic [SRC_NUM-1:0]   prio_r;             // 1 = high priority
	logic [PIN_COUNT-1:0] pin_pol_r;          // pin polarity
	logic [PIN_COUNT-1:0] pin_irqen_r;        // pin request enables
	logic [PIN_COUNT-1:0] pin_mask0_r;        // pin_select_mask_zero
	logic [PIN_COUNT-1:0] pin_mask1_r;        // second selection mask

	// flag and edge state
	logic [EDGE_NUM-1:0]  edge_flag_r;        // sticky edge flags
	logic [EDGE_NUM-1:0]  edge_flag_nxt;
	logic [EDGE_NUM-1:0]  edge_prev_r;        // previous edge source sample
	logic [IDLE_CNT_W-1:0] idle_cnt_r;        // bus idle time counter
	logic [IDLE_CNT_W-1:0] idle_cnt_nxt;

	// three-stage input synchroniser plus agreement filter
	logic [AW-1:0]        sync1_r;
	logic [AW-1:0]        sync2_r;
	logic [AW-1:0]        sync3_r;
	logic [AW-1:0]        filt_r;
	logic [AW-1:0]        filt_nxt;

	// apb and core request output registers
	logic [DATA_W-1:0]    prdata_r;
	logic                 pready_r;
	logic                 pslverr_r;
	logic                 core_irq_r;
	logic [SRC_ID_W-1:0]  core_irq_source_r;
	logic                 core_irq_high_r;

	// address decode
	wire logic [IDX_W-1:0] idx      = paddr[ADDR_W-1:2];
	wire logic             aligned  = (paddr[1:0] == 2'h0);
	wire logic             hit_en0  = aligned && (idx == IDX_ENABLE_0);
	wire logic             hit_en1  = aligned && (idx == IDX_ENABLE_1);
	wire logic             hit_en2  = aligned && (idx == IDX_ENABLE_2);
	wire logic             hit_glb  = aligned && (idx == IDX_GLOBAL);
	wire logic             hit_pr0  = aligned && (idx == IDX_PRIORITY_SELECT_0);
	wire logic             hit_pr1  = aligned && (idx == IDX_PRIORITY_SELECT_1);
	wire logic             hit_pr2  = aligned && (idx == IDX_PRIORITY_SELECT_2);
	wire logic             hit_fl0  = aligned && (idx == IDX_FLAGS_0);
	wire logic             hit_fl1  = aligned && (idx == IDX_FLAGS_1);
	wire logic             hit_fl2  = aligned && (idx == IDX_FLAGS_2);
	wire logic             hit_pol  = aligned && (idx == IDX_PIN_POL);
	wire logic             hit_pie  = aligned && (idx == IDX_PIN_IRQEN);
	wire logic             hit_pm0  = aligned && (idx == IDX_PIN_MASK0);
	wire logic             hit_pm1  = aligned && (idx == IDX_PIN_MASK1);
	wire logic             hit_any  = hit_en0 | hit_en1 | hit_en2 | hit_glb
		| hit_pr0 | hit_pr1 | hit_pr2 | hit_fl0 | hit_fl1 | hit_fl2
		| hit_pol | hit_pie | hit_pm0 | hit_pm1;

	// access phase strobes; the write lands at the edge that sees pready
	wire logic             access   = psel && penable;
	wire logic             wr_en    = access && pready_r && pwrite && hit_any;
	wire logic             rd_load  = access && !pready_r;

	// flag word: level sources low, edge sources high
	wire logic [SRC_NUM-1:0] flags  = {edge_flag_r, level_requests};

	// read data mux
	wire logic [DATA_W-1:0] rd_data =
		hit_en0 ? DATA_W'(enable_r[7:0])          :
		hit_en1 ? DATA_W'(enable_r[15:8])         :
		hit_en2 ? DATA_W'(enable_r[23:16])        :
		hit_glb ? DATA_W'(global_r)               :
		hit_pr0 ? DATA_W'(prio_r[7:0])            :
		hit_pr1 ? DATA_W'(prio_r[15:8])           :
		hit_pr2 ? DATA_W'(prio_r[23:16])          :
		hit_fl0 ? DATA_W'(flags[7:0])             :
		hit_fl1 ? DATA_W'(flags[15:8])            :
		hit_fl2 ? DATA_W'(flags[23:16])           :
		hit_pol ? DATA_W'(pin_pol_r)              :
		hit_pie ? DATA_W'(pin_irqen_r)            :
		hit_pm0 ? DATA_W'(pin_mask0_r)            :
		hit_pm1 ? DATA_W'(pin_mask1_r)            :
		{DATA_W{1'b0}};

	// synchronised pins, polarity corrected; polarity acts at once, so a
	// polarity change on an inactive pin looks like a rising edge and sets a flag
	wire logic [PIN_COUNT-1:0] pin_sync  = filt_r[PIN_COUNT-1:0];
	wire logic [PIN_COUNT-1:0] pin_act   = pin_sync ^ pin_pol_r;
	wire logic pin_request   = |(pin_act & pin_irqen_r);
	wire logic pin_to_core_0 = |(pin_act & pin_mask0_r);
	wire logic pin_to_core_1 = |(pin_act & pin_mask1_r);
	wire logic stmr_sync     = filt_r[PIN_COUNT];
	wire logic lfw_sync      = filt_r[PIN_COUNT+1];

	// edge source levels in enable byte order
	wire logic [EDGE_NUM-1:0] edge_src =
		{1'b0, pin_to_core_1, pin_to_core_0, stmr_sync, lfw_sync,
		 pin_request, usb_bus_reset, 1'b0};

	// bus idle fires once when the idle time is reached; the counter then
	// parks one past the firing count so a cleared flag stays clear
	wire logic idle_done = (idle_cnt_r == IDLE_CNT_W'(IDLE_CYCLES));
	wire logic idle_fire = usb_link_idle && (idle_cnt_r == IDLE_LAST);

	// rising transitions plus the idle pulse
	wire logic [EDGE_NUM-1:0] edge_set =
		(edge_src & ~edge_prev_r)
		| (EDGE_NUM'(idle_fire) << EDGE_IDLE_BIT);

	// write one clears edge flags
	wire logic [EDGE_NUM-1:0] edge_clr =
		(wr_en && hit_fl2) ? pwdata[EDGE_NUM-1:0] : {EDGE_NUM{1'b0}};

	// pending sources after masking and the global gate
	wire logic [SRC_NUM-1:0] pending =
		flags & enable_r & {SRC_NUM{global_r}};
	wire logic [SRC_NUM-1:0] pend_high = pending & prio_r;
	wire logic               any_high  = |pend_high;
	wire logic [SRC_NUM-1:0] pick_set  = any_high ? pend_high : pending;

	// lowest-numbered set bit wins within a priority class
	// the loop walks downwards so the last hit is the lowest number
	function automatic logic [SRC_ID_W-1:0] first_set(input logic [SRC_NUM-1:0] v);
		logic [SRC_ID_W-1:0] id;
		id = {SRC_ID_W{1'b0}};
		for (int i = SRC_NUM - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				id = SRC_ID_W'(i);
			end
		end
		return id;
	endfunction

	wire logic [SRC_ID_W-1:0] pick_id = first_set(pick_set);

	// sticky edge flags: a set in the clearing cycle survives
	assign edge_flag_nxt = (edge_flag_r & ~edge_clr) | edge_set;

	// bus idle counter restarts whenever the link is busy
	assign idle_cnt_nxt = !usb_link_idle ? {IDLE_CNT_W{1'b0}} :
		idle_done ? idle_cnt_r :
		idle_cnt_r + IDLE_CNT_W'(1);

	// a change counts once the second and third stages agree
	assign filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));

	// input synchroniser chain
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			sync1_r <= {AW{1'b0}};
			sync2_r <= {AW{1'b0}};
			sync3_r <= {AW{1'b0}};
			filt_r  <= {AW{1'b0}};
		end
		else
		begin
			sync1_r <= {low_freq_wakeup_request, system_timer_request, pin_in};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r  <= filt_nxt;
		end
	end

	// edge detection state and flags
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			edge_prev_r <= FLAG_RST;
			edge_flag_r <= FLAG_RST;
			idle_cnt_r  <= {IDLE_CNT_W{1'b0}};
		end
		else
		begin
			edge_prev_r <= edge_src;
			edge_flag_r <= edge_flag_nxt;
			idle_cnt_r  <= idle_cnt_nxt;
		end
	end

	// enable and global control registers
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			enable_r <= ENABLE_RST;
			global_r <= GLOBAL_RST;
		end
		else
		begin
			// first byte: host, serial, fifo, dma, power-down, timers
			if (wr_en && hit_en0)
			begin
				enable_r[7:0] <= pwdata[7:0];
			end
			// second byte: pke, pwm, radio, five usb device lines
			if (wr_en && hit_en1)
			begin
				enable_r[15:8] <= pwdata[7:0];
			end
			// third byte: edge-type sources
			if (wr_en && hit_en2)
			begin
				enable_r[23:16] <= pwdata[7:0];
			end
			if (wr_en && hit_glb)
			begin
				global_r <= pwdata[GLOBAL_EN_BIT];
			end
		end
	end

	// priority registers
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			prio_r <= PRIO_RST;
		end
		else
		begin
			if (wr_en && hit_pr0)
			begin
				prio_r[7:0] <= pwdata[7:0];
			end
			if (wr_en && hit_pr1)
			begin
				prio_r[15:8] <= pwdata[7:0];
			end
			if (wr_en && hit_pr2)
			begin
				prio_r[23:16] <= pwdata[7:0];
			end
		end
	end

	// pin configuration registers
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pin_pol_r   <= {PIN_COUNT{1'b0}};
			pin_irqen_r <= {PIN_COUNT{1'b0}};
			pin_mask0_r <= {PIN_COUNT{1'b0}};
			pin_mask1_r <= {PIN_COUNT{1'b0}};
		end
		else
		begin
			if (wr_en && hit_pol)
			begin
				pin_pol_r <= pwdata[PIN_COUNT-1:0];
			end
			if (wr_en && hit_pie)
			begin
				pin_irqen_r <= pwdata[PIN_COUNT-1:0];
			end
			if (wr_en && hit_pm0)
			begin
				pin_mask0_r <= pwdata[PIN_COUNT-1:0];
			end
			if (wr_en && hit_pm1)
			begin
				pin_mask1_r <= pwdata[PIN_COUNT-1:0];
			end
		end
	end

	// apb answer: one wait state, data captured before pready
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= {DATA_W{1'b0}};
		end
		else
		begin
			pready_r <= rd_load;
			// error flag for unmapped words and misaligned addresses
			if (rd_load)
			begin
				pslverr_r <= !hit_any;
				prdata_r  <= pwrite ? {DATA_W{1'b0}} : rd_data;
			end
			else
			begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// request towards the core with chosen source
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			core_irq_r        <= 1'b0;
			core_irq_source_r <= {SRC_ID_W{1'b0}};
			core_irq_high_r   <= 1'b0;
		end
		else
		begin
			core_irq_r        <= |pending;
			core_irq_source_r <= pick_id;
			core_irq_high_r   <= any_high;
		end
	end

	// outputs straight from flip-flops
	assign prdata          = prdata_r;
	assign pready          = pready_r;
	assign pslverr         = pslverr_r;
	assign core_irq        = core_irq_r;
	assign core_irq_source = core_irq_source_r;
	assign core_irq_high   = core_irq_high_r;
endmodule

// [tb/irc_top_asserts.sv]
// Purpose: port-level checker for the interrupt request controller
// Assumes: one clock, async active-high reset, one apb wait state
// Notes:   shadows global enable and priority bytes from apb writes
`timescale 1ns/1ps
module irc_top_asserts
	import irc_pkg::*;
#(
	parameter int unsigned PIN_COUNT = 32
)
(
	input wire logic                 clock,
	input wire logic                 reset,
	input wire logic [15:0]          paddr,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic [15:0]          level_requests,
	input wire logic                 usb_bus_reset,
	input wire logic                 usb_link_idle,
	input wire logic                 system_timer_request,
	input wire logic                 low_freq_wakeup_request,
	input wire logic [PIN_COUNT-1:0] pin_in,
	input wire logic                 core_irq,
	input wire logic [4:0]           core_irq_source,
	input wire logic                 core_irq_high
);
	logic [23:0] prio_r;  // priority bits as written
	logic [23:0] prio_d;  // one cycle late, matches registered outputs
	logic        glob_r;  // global enable as written
	logic        glob_d;  // one cycle late
	wire  [13:0] idx = paddr[15:2];
	wire         wr_ok = psel && penable && pready && pwrite && !pslverr;
	wire         mapped = (paddr[1:0] == 2'h0) && ((idx >= IDX_ENABLE_0 && idx <= IDX_PRIORITY_SELECT_2)
		|| (idx >= IDX_FLAGS_0 && idx <= IDX_FLAGS_2) || (idx >= IDX_PIN_POL && idx <= IDX_PIN_MASK1));
	// shadow the control fields on completed writes
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			{prio_r, prio_d, glob_r, glob_d} <= '0;
		end
		else
		begin
			prio_d <= prio_r;
			glob_d <= glob_r;
			if (wr_ok && idx == IDX_GLOBAL) glob_r <= pwdata[0];
			if (wr_ok && idx == IDX_PRIORITY_SELECT_0) prio_r[7:0] <= pwdata[7:0];
			if (wr_ok && idx == IDX_PRIORITY_SELECT_1) prio_r[15:8] <= pwdata[7:0];
			if (wr_ok && idx == IDX_PRIORITY_SELECT_2) prio_r[23:16] <= pwdata[7:0];
		end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	a_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("apb answer not on second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("slave error does not match address map");
	a_byte_width: assert property (pready && !pwrite && idx < IDX_PIN_POL |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_gate_global: assert property (core_irq |-> glob_d)
		else $error("core request without global enable");
	a_prio_class: assert property (core_irq |-> core_irq_high == prio_d[core_irq_source])
		else $error("priority class wrong");
	a_src_range: assert property (core_irq |-> core_irq_source < 5'd24)
		else $error("source number out of range");
	a_reset_quiet: assert property ($fell(reset) |-> !core_irq && !pready)
		else $error("outputs active after reset");
endmodule
bind irc_top irc_top_asserts #(.PIN_COUNT(PIN_COUNT)) u_chk (.clock, .reset, .paddr, .psel,
	.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .level_requests, .usb_bus_reset,
	.usb_link_idle, .system_timer_request, .low_freq_wakeup_request, .pin_in, .core_irq,
	.core_irq_source, .core_irq_high);

// [tb/irc_core_model.sv]
// Purpose: processor core taking the combined request
// Assumes: request is a level held until software clears its cause
// Notes:   latency sets a prompt or a slow core
`timescale 1ns/1ps
module irc_core_model
#(
	parameter int unsigned LATENCY = 1  // cycles before the core responds
)
(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       core_irq,
	input  wire logic [4:0] core_irq_source,
	output int              taken
);
	int wait_cnt;  // cycles the request has stood
	// accept once per request after the latency, then stay in service
	always @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			taken    <= 0;
			wait_cnt <= 0;
		end
		else if (core_irq !== 1'b1)
		begin
			wait_cnt <= 0;
		end
		else
		begin
			if (wait_cnt < LATENCY)
				wait_cnt <= wait_cnt + 1;
			if (wait_cnt == LATENCY - 1)
				taken <= taken + 1;
		end
	end
endmodule

// [tb/interrupt_request_controller_bench.sv]
// Purpose: self-checking bench for the interrupt request controller
// Assumes: apb master, 10 MHz clock, async pins settle within 8 cycles
// Notes:   reads queue expected {pslverr, prdata}; a monitor compares
`timescale 1ns/1ps
module interrupt_request_controller_bench;
	import irc_pkg::*;
	logic        clock, reset, psel, penable, pwrite, pready, pslverr, core_irq, core_irq_high;
	logic [15:0] paddr, level_requests, lv;
	logic [31:0] pwdata, prdata, v;
	logic        usb_bus_reset, usb_link_idle, system_timer_request, low_freq_wakeup_request;
	logic [31:0] pin_in;
	logic [4:0]  core_irq_source;
	logic [32:0] exp_q[$];  // expected read results
	int          errors, total_checks, taken_a, taken_b, i;
	irc_top uut (.clock, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .level_requests, .usb_bus_reset, .usb_link_idle, .system_timer_request,
		.low_freq_wakeup_request, .pin_in, .core_irq, .core_irq_source, .core_irq_high);
	irc_core_model #(.LATENCY(1)) u_fast (.clock, .reset, .core_irq, .core_irq_source, .taken(taken_a));
	irc_core_model #(.LATENCY(5)) u_slow (.clock, .reset, .core_irq, .core_irq_source, .taken(taken_b));
	initial
	begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
		total_checks++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one apb transfer; reads note the expected result
	task automatic ap(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
		int n;
		@(posedge clock);
		{paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 2'b10};
		if (!w) exp_q.push_back(e);
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clock);
		end
		if (n >= 20) begin chk("timeout", 1, 0); close_out(); end
		{psel, penable} <= 2'b00;
	endtask
	// request state after the registered outputs settle
	task automatic cc(input logic q, input logic [4:0] s, input logic h);
		repeat (3) @(posedge clock);
		chk("irq", core_irq, q);
		if (q) chk("src", {core_irq_high, core_irq_source}, {h, s});
	endtask
	// drive one edge-type source by its flag bit
	task automatic src(input int b, input logic x);
		case (b)
			1: usb_bus_reset <= x;
			2: pin_in[3] <= x;
			3: low_freq_wakeup_request <= x;
			4: system_timer_request <= x;
			5: pin_in[5] <= x;
			default: pin_in[7] <= x;
		endcase
	endtask
	// result monitor: oldest note against each read answer
	always @(posedge clock)
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			if (exp_q.size() == 0) chk("queue", 1, 0);
			else chk("rdata", {pslverr, prdata}, exp_q.pop_front());
		end
	initial
	begin
		repeat (100000) @(posedge clock);
		chk("run timeout", 1, 0);
		close_out();
	end
	initial
	begin
		{reset, psel, penable, pwrite, paddr, pwdata, level_requests, pin_in} = '0;
		{usb_bus_reset, usb_link_idle, system_timer_request, low_freq_wakeup_request} = '0;
		reset = 1'b1;
		void'($urandom(63));
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		for (i = 0; i < 11; i++) ap(16'h1900 + 16'(i * 4), 0, 0, {i == 7, 32'h0});
		ap(16'h1902, 0, 0, {1'b1, 32'h0});
		ap(16'h1930, 1, 32'hFF, 0);
		ap(16'h1930, 0, 0, {1'b1, 32'h0});
		for (i = 0; i < 7; i++)
			if (i != 3)
			begin
				v = $urandom;
				ap(16'h1900 + 16'(i * 4), 1, v, 0);
				ap(16'h1900 + 16'(i * 4), 0, 0, {25'h0, v[7:0]});
			end
		ap(16'h190C, 1, 1, 0);
		ap(16'h190C, 0, 0, 33'h1);
		lv = 16'($urandom);
		level_requests <= lv;
		ap(16'h1920, 1, 32'hFF, 0);
		ap(16'h1920, 0, 0, {25'h0, lv[7:0]});
		ap(16'h1924, 0, 0, {25'h0, lv[15:8]});
		ap(16'h190C, 1, 0, 0);
		level_requests <= 16'h8001;
		for (i = 0; i < 7; i++) if (i != 3) ap(16'h1900 + 16'(i * 4), 1, 0, 0);
		ap(16'h1900, 1, 1, 0);
		ap(16'h1904, 1, 32'h80, 0);
		cc(0, 0, 0);
		ap(16'h190C, 1, 1, 0);
		cc(1, 0, 0);
		ap(16'h1914, 1, 32'h80, 0);
		cc(1, 15, 1);
		ap(16'h1900, 1, 0, 0);
		level_requests <= 16'h0001;
		cc(0, 0, 0);
		level_requests <= 0;
		ap(16'h1908, 1, 32'h7F, 0);
		ap(16'h1944, 1, 32'h8, 0);
		ap(16'h1948, 1, 32'h20, 0);
		ap(16'h194C, 1, 32'h80, 0);
		for (i = 1; i < 7; i++)
		begin
			src(i, 1);
			repeat (8) @(posedge clock);
			ap(16'h1928, 0, 0, {25'h0, 8'(1 << i)});
			cc(1, 5'(16 + i), 0);
			src(i, 0);
			repeat (8) @(posedge clock);
			ap(16'h1928, 0, 0, {25'h0, 8'(1 << i)});
			ap(16'h1928, 1, 32'(1 << i), 0);
			ap(16'h1928, 0, 0, 0);
		end
		ap(16'h1940, 1, 32'h8, 0);
		ap(16'h1928, 0, 0, {25'h0, 8'h04});
		ap(16'h1928, 1, 32'h4, 0);
		usb_link_idle <= 1'b1;
		repeat (2400) @(posedge clock);
		ap(16'h1928, 0, 0, 0);
		repeat (200) @(posedge clock);
		ap(16'h1928, 0, 0, 33'h1);
		ap(16'h1928, 1, 1, 0);
		ap(16'h1928, 0, 0, 0);
		usb_link_idle <= 1'b0;
		repeat (4) @(posedge clock);
		chk("taken", {taken_a > 0, taken_b > 0}, 2'b11);
		close_out();
	end
endmodule
